// ### design/codec_mode_control_regs.sv
// Operation
// (RULE1) Format selector in bits 1..0 of register 04h, reset 10 left-justified.
// (RULE2) Synthesizer reference select in bits 7..4 of 04h, reset 0000.
// (RULE3) Bit 3 of 04h picks bit-clock output rate in master mode.
// (RULE4) Rate field means sample rate with synthesizer, master-clock rate otherwise.
// (RULE5) Bit-clock polarity bit swaps launch and sample edges in DSP format.
// (RULE6) Frame polarity bit sets frame edge half or one bit before change.
// (RULE7) Bits 7..6 of 05h select master-clock output rate, reset 256fs.
// (RULE8) Fast recovery speed in bits 1..0 of 06h, reset four times.
// (RULE9) Recovery wait and zero-cross timeout fields reset to 128 samples.
// (RULE10) Transition time bit picks 1061 or 256 sample periods.
// (RULE11) Limiter level and gain step split between 0Bh and 07h.
// (RULE12) Bit 4 of 07h set turns off limiter zero-cross detection.
// (RULE13) Level control runs only while bit 5 of 07h is one.
// (RULE14) Recovery reference level eight bits, reset E1h.
// (RULE15) Left and right input volumes eight bits, reset E1h.
// (RULE16) Left and right output volumes reset to 18h.
// (RULE17) Output link set: left output volume drives both, right untouched.
// (RULE18) Input link set: left input volume drives both, right untouched.
// (RULE19) De-emphasis resets 01, bass boost resets 00, in 0Eh.
// (RULE20) Loopback bit chooses transmit data instead of receive data for DAC.
// (RULE21) Soft mute bit one mutes DAC outputs.
// (RULE22) Headphone mono bit averages left and right onto both channels.
// (RULE23) Power-down pin low returns all registers to defaults.
// (RULE24) Host writes zero into all unused bit positions.
// (RULE25) Each written byte lands at once and takes effect without more commands.
// (RULE26) Unused bit positions read back as zero.
`timescale 1ns/1ps
`default_nettype none

module codec_mode_control_regs
  import codec_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Pins from the board.
  input wire logic power_down_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Clock mode from the power block, same clock.
  input wire logic synth_mode,
  // Serial format and clocking.
  output logic [1:0] serial_format_sel,
  output logic [3:0] synth_ref_sel,
  output logic bitclk_out_rate,
  output logic [3:0] synth_rate_sel,
  output logic [3:0] mclk_in_sel,
  output logic bitclk_polarity,
  output logic frame_polarity,
  output logic [1:0] mclk_out_rate,
  // Level control.
  output logic [1:0] fast_recovery_speed,
  output logic [2:0] recovery_wait,
  output logic [1:0] zero_cross_timeout,
  output logic [10:0] vol_transition_time,
  output logic [1:0] limiter_level,
  output logic [1:0] recovery_gain_step,
  output logic [1:0] limiter_atten_step,
  output logic limiter_zero_cross_off,
  output logic level_ctrl_on,
  output logic [7:0] recovery_reference,
  // Effective channel volumes.
  output logic [7:0] left_in_vol,
  output logic [7:0] right_in_vol,
  output logic [7:0] left_out_vol,
  output logic [7:0] right_out_vol,
  // Playback and routing.
  output logic [1:0] deemph_sel,
  output logic [1:0] bass_boost_sel,
  output logic soft_mute,
  output logic dac_from_tx,
  output logic headphone_mono,
  output logic [7:0] record_input_sel,
  output logic [7:0] filter_enable_bits
);

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] pd_s;
    logic scl_d;
    logic sda_d;
    port_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] addr;
    logic sda_oe_n;
    logic sda_out;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0] right_in_eff;
    logic [7:0] right_out_eff;
    logic [3:0] synth_rate;
    logic [3:0] mclk_in;
    logic [10:0] vol_time;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic wr_fire;

  // Maps a bus offset onto a storage slot; bit 4 flags a mapped offset.
  function automatic logic [4:0] reg_slot(input logic [7:0] ofs);
    logic [7:0] diff;
    diff = ofs - REG_FIRST;
    reg_slot = {(ofs >= REG_FIRST) && (ofs <= REG_LAST), diff[3:0]};
  endfunction

  // Read data for an offset; unmapped offsets read as zero.
  function automatic logic [7:0] reg_read(input logic [REG_COUNT-1:0][7:0] regs, input logic [7:0] ofs);
    logic [4:0] slot;
    slot = reg_slot(ofs);
    reg_read = slot[4] ? regs[slot[3:0]] : 8'h00;
  endfunction

  // Bus line conditions seen on the synchronised copies only.
  assign scl = state_r.scl_s[1];
  assign sda = state_r.sda_s[1];
  assign scl_rise = scl && !state_r.scl_d;
  assign scl_fall = !scl && state_r.scl_d;
  assign start_cond = scl && state_r.scl_d && !sda && state_r.sda_d;
  assign stop_cond = scl && state_r.scl_d && sda && !state_r.sda_d;

  // Next-state logic for the control port and register storage.
  always_comb begin
    logic [4:0] slot;
    logic [7:0] rdat;
    state_nxt = state_r;
    wr_fire = 1'b0;
    slot = reg_slot(state_r.addr);
    rdat = reg_read(state_r.regs, state_r.addr);
    state_nxt.scl_s = {state_r.scl_s[0], scl_in};
    state_nxt.sda_s = {state_r.sda_s[0], sda_in};
    state_nxt.pd_s = {state_r.pd_s[0], power_down_n};
    state_nxt.scl_d = scl;
    state_nxt.sda_d = sda;
    state_nxt.sda_out = 1'b0;
    if (start_cond) begin
      // A repeated start restarts the address phase at any point.
      state_nxt.st = ST_DEV;
      state_nxt.bitcnt = 4'h0;
      state_nxt.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      state_nxt.st = ST_IDLE;
      state_nxt.sda_oe_n = 1'b1;
    end else begin
      unique case (state_r.st)
        ST_IDLE: begin
          state_nxt.sda_oe_n = 1'b1;
        end
        ST_DEV, ST_REG, ST_WR: begin
          if (scl_rise) begin
            state_nxt.shreg = {state_r.shreg[6:0], sda};
            state_nxt.bitcnt = state_r.bitcnt + 4'h1;
          end else if (scl_fall && state_r.bitcnt == BITS_PER_BYTE) begin
            state_nxt.bitcnt = 4'h0;
            state_nxt.sda_oe_n = 1'b0;
            if (state_r.st == ST_DEV) begin
              // Another device's address: stay off the bus until the next start.
              if (state_r.shreg[7:1] == DEV_ADDR) begin
                state_nxt.rw = state_r.shreg[0];
                state_nxt.st = ST_DEV_ACK;
              end else begin
                state_nxt.sda_oe_n = 1'b1;
                state_nxt.st = ST_IDLE;
              end
            end else if (state_r.st == ST_REG) begin
              state_nxt.addr = state_r.shreg;
              state_nxt.st = ST_REG_ACK;
            end else begin
              wr_fire = 1'b1; // RULE25
              state_nxt.st = ST_WR_ACK;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            if (state_r.rw) begin
              state_nxt.shreg = rdat;
              state_nxt.sda_oe_n = rdat[7];
              state_nxt.bitcnt = 4'h1;
              state_nxt.st = ST_RD;
            end else begin
              state_nxt.sda_oe_n = 1'b1;
              state_nxt.st = ST_REG;
            end
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            state_nxt.sda_oe_n = 1'b1;
            state_nxt.st = ST_WR;
          end
        end
        ST_WR_ACK: begin
          // Auto-increment lets a burst fill consecutive registers.
          if (scl_fall) begin
            state_nxt.sda_oe_n = 1'b1;
            state_nxt.addr = state_r.addr + 8'h01;
            state_nxt.st = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (state_r.bitcnt == BITS_PER_BYTE) begin
              state_nxt.sda_oe_n = 1'b1;
              state_nxt.bitcnt = 4'h0;
              state_nxt.st = ST_RD_ACK;
            end else begin
              state_nxt.sda_oe_n = state_r.shreg[6];
              state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
              state_nxt.bitcnt = state_r.bitcnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // A not-acknowledge ends the read; an acknowledge fetches the next offset.
          if (scl_rise) begin
            if (sda) begin
              state_nxt.st = ST_IDLE;
            end else begin
              state_nxt.addr = state_r.addr + 8'h01;
              state_nxt.bitcnt = 4'h1;
            end
          end else if (scl_fall && state_r.bitcnt == 4'h1) begin
            state_nxt.shreg = rdat;
            state_nxt.sda_oe_n = rdat[7];
            state_nxt.st = ST_RD;
          end
        end
        default: begin
          state_nxt.st = ST_IDLE;
          state_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
    // Power-down wins over a write landing in the same cycle.
    if (!state_r.pd_s[1]) begin
      state_nxt.regs = REG_DEFAULTS; // RULE23
    end else if (wr_fire && slot[4]) begin
      state_nxt.regs[slot[3:0]] = state_r.shreg & REG_MASKS[slot[3:0]]; // RULE26
    end
    // Derived values lag the storage by one cycle so every output is a flop.
    state_nxt.right_in_eff = state_r.regs[IX_HP][FB_IN_LINK] ? state_r.regs[IX_LIN] : state_r.regs[IX_RIN]; // RULE18
    state_nxt.right_out_eff = state_r.regs[IX_EFX][FB_OUT_LINK] ? state_r.regs[IX_LOUT] :
      state_r.regs[IX_ROUT]; // RULE17
    state_nxt.synth_rate = synth_mode ? {state_r.regs[IX_RATE][FB_RATE3], state_r.regs[IX_RATE][2:0]} : 4'h0; // RULE4
    state_nxt.mclk_in = synth_mode ? 4'h0 : {state_r.regs[IX_RATE][FB_RATE3], state_r.regs[IX_RATE][2:0]}; // RULE4
    state_nxt.vol_time = state_r.regs[IX_TMR][FB_VOL_TIME] ? VOL_TIME_FAST : VOL_TIME_SLOW; // RULE10
  end

  // All state in one register; reset loads constants only.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      state_r.scl_s <= 2'h3;
      state_r.sda_s <= 2'h3;
      state_r.scl_d <= 1'b1;
      state_r.sda_d <= 1'b1;
      state_r.st <= ST_IDLE;
      state_r.sda_oe_n <= 1'b1;
      state_r.regs <= REG_DEFAULTS;
      state_r.right_in_eff <= REG_DEFAULTS[IX_LIN];
      state_r.right_out_eff <= REG_DEFAULTS[IX_LOUT];
      state_r.vol_time <= VOL_TIME_SLOW;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Field outputs taken straight from the storage flops or the derived-value flops.
  assign sda_out = state_r.sda_out;
  assign sda_oe_n = state_r.sda_oe_n;
  assign serial_format_sel = state_r.regs[IX_FMT][1:0]; // RULE1
  assign synth_ref_sel = state_r.regs[IX_FMT][7:4]; // RULE2
  assign bitclk_out_rate = state_r.regs[IX_FMT][FB_BCLK_RATE]; // RULE3
  assign synth_rate_sel = state_r.synth_rate;
  assign mclk_in_sel = state_r.mclk_in;
  assign bitclk_polarity = state_r.regs[IX_RATE][FB_BCLK_POL]; // RULE5
  assign frame_polarity = state_r.regs[IX_RATE][FB_FRAME_POL]; // RULE6
  assign mclk_out_rate = state_r.regs[IX_RATE][7:6]; // RULE7
  assign fast_recovery_speed = state_r.regs[IX_TMR][1:0]; // RULE8
  assign recovery_wait = {state_r.regs[IX_TMR][6], state_r.regs[IX_TMR][3:2]}; // RULE9
  assign zero_cross_timeout = state_r.regs[IX_TMR][5:4]; // RULE9
  assign vol_transition_time = state_r.vol_time;
  assign limiter_level = {state_r.regs[IX_LCB][FB_LIM_HI], state_r.regs[IX_LCA][FB_LIM_LO]}; // RULE11
  assign recovery_gain_step = {state_r.regs[IX_LCB][FB_GAIN_HI], state_r.regs[IX_LCA][FB_GAIN_LO]}; // RULE11
  assign limiter_atten_step = state_r.regs[IX_LCA][3:2];
  assign limiter_zero_cross_off = state_r.regs[IX_LCA][FB_ZC_OFF]; // RULE12
  assign level_ctrl_on = state_r.regs[IX_LCA][FB_LEVEL_ON]; // RULE13
  assign recovery_reference = state_r.regs[IX_REF]; // RULE14
  assign left_in_vol = state_r.regs[IX_LIN]; // RULE15
  assign right_in_vol = state_r.right_in_eff;
  assign left_out_vol = state_r.regs[IX_LOUT]; // RULE16
  assign right_out_vol = state_r.right_out_eff;
  assign deemph_sel = state_r.regs[IX_EFX][1:0]; // RULE19
  assign bass_boost_sel = state_r.regs[IX_EFX][3:2]; // RULE19
  assign soft_mute = state_r.regs[IX_EFX][FB_MUTE]; // RULE21
  assign dac_from_tx = state_r.regs[IX_EFX][FB_LOOP]; // RULE20
  assign headphone_mono = state_r.regs[IX_HP][FB_HP_MONO]; // RULE22
  assign record_input_sel = state_r.regs[IX_REC];
  assign filter_enable_bits = state_r.regs[IX_FIL];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_dev_byte_done;
    state_r.st == ST_DEV && scl_fall && state_r.bitcnt == BITS_PER_BYTE && state_r.shreg[7:1] == DEV_ADDR;
  endsequence
  sequence s_ack_driven;
    state_r.st == ST_DEV_ACK && !sda_oe_n;
  endsequence

  property p_dev_ack;
    s_dev_byte_done |=> s_ack_driven;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("device address not acknowledged"); // RULE25

  property p_power_down;
    !state_r.pd_s[1] |=> serial_format_sel == 2'h2 && left_out_vol == 8'h18 && recovery_reference == 8'hE1;
  endproperty
  a_power_down: assert property (p_power_down) else $error("defaults not restored in power-down"); // RULE23

  property p_out_link;
    ##1 right_out_vol == ($past(state_r.regs[IX_EFX][FB_OUT_LINK]) ? $past(left_out_vol) :
      $past(state_r.regs[IX_ROUT]));
  endproperty
  a_out_link: assert property (p_out_link) else $error("right output volume wrong for link mode"); // RULE17

  property p_in_link;
    ##1 right_in_vol == ($past(state_r.regs[IX_HP][FB_IN_LINK]) ? $past(left_in_vol) : $past(state_r.regs[IX_RIN]));
  endproperty
  a_in_link: assert property (p_in_link) else $error("right input volume wrong for link mode"); // RULE18

  property p_write_lands;
    wr_fire && state_r.addr == OFS_PLAYBACK_EFFECTS && state_r.pd_s[1] |=>
      soft_mute == $past(state_r.shreg[FB_MUTE]) && dac_from_tx == $past(state_r.shreg[FB_LOOP]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("written byte did not take effect"); // RULE25

  property p_unused_zero;
    state_r.regs[IX_FMT][2] == 1'b0 && state_r.regs[IX_HP][7:4] == 4'h0 && state_r.regs[IX_LCB][5:2] == 4'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit holds a one"); // RULE26
  property p_rate_split;
    ##1 (synth_rate_sel == 4'h0 || mclk_in_sel == 4'h0) &&
      ($past(synth_mode) ? mclk_in_sel == 4'h0 : synth_rate_sel == 4'h0);
  endproperty
  a_rate_split: assert property (p_rate_split) else $error("rate field routed to wrong meaning"); // RULE4

  property p_vol_time;
    ##1 vol_transition_time == ($past(state_r.regs[IX_TMR][FB_VOL_TIME]) ? 11'h100 : 11'h425);
  endproperty
  a_vol_time: assert property (p_vol_time) else $error("transition time mismatch"); // RULE10

endmodule

`default_nettype wire

// ### common/codec_regs_pkg.sv
`default_nettype none
package codec_regs_pkg;

  // Register window reached over the two-wire control port.
  localparam int REG_COUNT = 14;
  localparam logic [7:0] REG_FIRST = 8'h04;
  localparam logic [7:0] REG_LAST = 8'h11;

  // Byte offsets of the registers.
  localparam logic [7:0] OFS_FORMAT_AND_PLL_SOURCE = 8'h04;
  localparam logic [7:0] OFS_RATE_AND_CLOCK_POLARITY = 8'h05;
  localparam logic [7:0] OFS_LEVEL_CONTROL_TIMERS = 8'h06;
  localparam logic [7:0] OFS_LEVEL_CONTROL_MODE_A = 8'h07;
  localparam logic [7:0] OFS_RECOVERY_REFERENCE_LEVEL = 8'h08;
  localparam logic [7:0] OFS_LEFT_INPUT_VOLUME = 8'h09;
  localparam logic [7:0] OFS_LEFT_OUTPUT_VOLUME = 8'h0A;
  localparam logic [7:0] OFS_LEVEL_CONTROL_MODE_B = 8'h0B;
  localparam logic [7:0] OFS_RIGHT_INPUT_VOLUME = 8'h0C;
  localparam logic [7:0] OFS_RIGHT_OUTPUT_VOLUME = 8'h0D;
  localparam logic [7:0] OFS_PLAYBACK_EFFECTS = 8'h0E;
  localparam logic [7:0] OFS_HEADPHONE_ROUTING = 8'h0F;
  localparam logic [7:0] OFS_RECORD_INPUT_SELECT = 8'h10;
  localparam logic [7:0] OFS_FILTER_ENABLES = 8'h11;

  // Slot of each register in the storage array (offset minus first offset).
  localparam int IX_FMT = 0;
  localparam int IX_RATE = 1;
  localparam int IX_TMR = 2;
  localparam int IX_LCA = 3;
  localparam int IX_REF = 4;
  localparam int IX_LIN = 5;
  localparam int IX_LOUT = 6;
  localparam int IX_LCB = 7;
  localparam int IX_RIN = 8;
  localparam int IX_ROUT = 9;
  localparam int IX_EFX = 10;
  localparam int IX_HP = 11;
  localparam int IX_REC = 12;
  localparam int IX_FIL = 13;

  // Reset values, slot 13 first and slot 0 last.
  localparam logic [REG_COUNT-1:0][7:0] REG_DEFAULTS = {
    8'h00, 8'h00, 8'h08, 8'h11, 8'h18, 8'hE1, 8'h00,
    8'h18, 8'hE1, 8'hE1, 8'h00, 8'h00, 8'h00, 8'h02};

  // Writable bits; unused positions are forced to zero.
  localparam logic [REG_COUNT-1:0][7:0] REG_MASKS = {
    8'hDC, 8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hC2,
    8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFB};

  // Field positions.
  localparam int FB_BCLK_RATE = 3;
  localparam int FB_RATE3 = 5;
  localparam int FB_FRAME_POL = 4;
  localparam int FB_BCLK_POL = 3;
  localparam int FB_VOL_TIME = 7;
  localparam int FB_LEVEL_ON = 5;
  localparam int FB_ZC_OFF = 4;
  localparam int FB_LIM_LO = 0;
  localparam int FB_GAIN_LO = 1;
  localparam int FB_LIM_HI = 6;
  localparam int FB_GAIN_HI = 7;
  localparam int FB_OUT_LINK = 4;
  localparam int FB_MUTE = 5;
  localparam int FB_LOOP = 6;
  localparam int FB_IN_LINK = 3;
  localparam int FB_HP_MONO = 2;

  // Output volume full-scale transition time, in sample periods.
  localparam logic [10:0] VOL_TIME_SLOW = 11'h425;
  localparam logic [10:0] VOL_TIME_FAST = 11'h100;

  // Control port bus address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h12;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Control port states, Gray steps along the write path.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_REG = 4'h2,
    ST_REG_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hC
  } port_state_e;

endpackage

`default_nettype wire

// ### tb/ctl_host.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural host on the two-wire control port; it only pulls SDA low or lets it go.
module ctl_host (
  // Clock.
  input wire logic ref_clk,
  // Wire side.
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // Both lines idle high, nothing pulled.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Phases span several cycles so the device's synchronisers see every level.
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Data changes only well inside the low phase, never near an SCL edge.
  task automatic put_bit(input logic b, output logic seen);
    tick(4);
    sda_pull = ~b;
    tick(4);
    scl = 1'b1;
    tick(6);
    seen = sda_line;
    scl = 1'b0;
  endtask

  // Start, or repeated start: SDA falls while SCL is high.
  task automatic start_cond();
    tick(4);
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_pull = 1'b1;
    tick(6);
    scl = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high.
  task automatic stop_cond();
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_pull = 1'b0;
    tick(6);
  endtask

  // Byte out MSB first, then the ninth clock returns the acknowledge.
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // Byte in MSB first; the host acknowledges only when more bytes follow.
  task automatic recv_byte(input logic more, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      v[i] = s;
    end
    put_bit(~more, s);
  endtask

  // One or two data bytes written from a starting offset.
  task automatic write_seq(input logic [6:0] addr, input logic [7:0] ofs, input logic [7:0] d0,
                           input logic [7:0] d1, input int n, output logic ok);
    logic a;
    start_cond();
    send_byte({addr, 1'b0}, a);
    ok = a;
    if (a) begin
      send_byte(ofs, a);
      ok = ok & a;
      send_byte(d0, a);
      ok = ok & a;
      if (n > 1) begin
        send_byte(d1, a);
        ok = ok & a;
      end
    end
    stop_cond();
  endtask

  // Offset set by a write phase, then a repeated start and one byte read.
  task automatic read_seq(input logic [6:0] addr, input logic [7:0] ofs, output logic [7:0] v, output logic ok);
    logic a;
    start_cond();
    send_byte({addr, 1'b0}, a);
    ok = a;
    send_byte(ofs, a);
    ok = ok & a;
    start_cond();
    send_byte({addr, 1'b1}, a);
    ok = ok & a;
    recv_byte(1'b0, v);
    stop_cond();
  endtask
endmodule

`default_nettype wire

// ### tb/codec_mode_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module codec_mode_control_regs_tb;
  import codec_regs_pkg::*;
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [7:0] rd;} row_s;
  localparam logic [7:0] DFLT [14] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'hE1, 8'hE1, 8'h18,
                                      8'h00, 8'hE1, 8'h18, 8'h11, 8'h08, 8'h00, 8'h00};
  // Rows keep unused bits zero, except those whose read value differs from the written one, which test read-back of unused bits.
  localparam row_s ROWS [16] = '{'{8'h04, 8'hA9, 8'hA9}, '{8'h05, 8'hD6, 8'hD6}, '{8'h05, 8'h2B, 8'h2B},
    '{8'h06, 8'hC9, 8'hC9}, '{8'h06, 8'h36, 8'h36}, '{8'h07, 8'hFF, 8'h3F}, '{8'h08, 8'h12, 8'h12},
    '{8'h09, 8'hF1, 8'hF1}, '{8'h0A, 8'h9C, 8'h9C}, '{8'h0B, 8'hFF, 8'hC2}, '{8'h0C, 8'h55, 8'h55},
    '{8'h0D, 8'h77, 8'h77}, '{8'h0E, 8'h6E, 8'h6E}, '{8'h0F, 8'hF7, 8'h07}, '{8'h10, 8'hA5, 8'hA5},
    '{8'h11, 8'hFF, 8'hDC}};
  logic ref_clk, rst, power_down_n, synth_mode, scl, sda_pull, sda_out, sda_oe_n, sda_wire, ok;
  logic bitclk_out_rate, bitclk_polarity, frame_polarity, limiter_zero_cross_off, level_ctrl_on;
  logic soft_mute, dac_from_tx, headphone_mono;
  logic [1:0] serial_format_sel, mclk_out_rate, fast_recovery_speed, zero_cross_timeout, limiter_level;
  logic [1:0] recovery_gain_step, limiter_atten_step, deemph_sel, bass_boost_sel;
  logic [2:0] recovery_wait;
  logic [3:0] synth_ref_sel, synth_rate_sel, mclk_in_sel;
  logic [10:0] vol_transition_time;
  logic [7:0] recovery_reference, left_in_vol, right_in_vol, left_out_vol, right_out_vol;
  logic [7:0] record_input_sel, filter_enable_bits;
  logic [7:0] shadow [14];
  int n_mismatch = 0;
  int cmp_count = 0;

  // Open-drain data line with a pull-up: low if either party pulls.
  assign sda_wire = !sda_pull && (sda_oe_n || sda_out);

  codec_mode_control_regs dut_u (.ref_clk(ref_clk), .rst(rst), .power_down_n(power_down_n), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .synth_mode(synth_mode),
    .serial_format_sel(serial_format_sel), .synth_ref_sel(synth_ref_sel), .bitclk_out_rate(bitclk_out_rate),
    .synth_rate_sel(synth_rate_sel), .mclk_in_sel(mclk_in_sel), .bitclk_polarity(bitclk_polarity),
    .frame_polarity(frame_polarity), .mclk_out_rate(mclk_out_rate), .fast_recovery_speed(fast_recovery_speed),
    .recovery_wait(recovery_wait), .zero_cross_timeout(zero_cross_timeout),
    .vol_transition_time(vol_transition_time), .limiter_level(limiter_level),
    .recovery_gain_step(recovery_gain_step), .limiter_atten_step(limiter_atten_step),
    .limiter_zero_cross_off(limiter_zero_cross_off), .level_ctrl_on(level_ctrl_on),
    .recovery_reference(recovery_reference), .left_in_vol(left_in_vol), .right_in_vol(right_in_vol),
    .left_out_vol(left_out_vol), .right_out_vol(right_out_vol), .deemph_sel(deemph_sel),
    .bass_boost_sel(bass_boost_sel), .soft_mute(soft_mute), .dac_from_tx(dac_from_tx),
    .headphone_mono(headphone_mono), .record_input_sel(record_input_sel), .filter_enable_bits(filter_enable_bits));

  ctl_host host_u (.ref_clk(ref_clk), .sda_line(sda_wire), .scl(scl), .sda_pull(sda_pull));

  // 25 MHz reference clock.
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Every field output worked out from the shadow copy of the registers.
  task automatic check_fields();
    logic [7:0] s [14];
    s = shadow;
    check("format", {serial_format_sel, synth_ref_sel, bitclk_out_rate},
          {s[0][1:0], s[0][7:4], s[0][3]});
    check("rate", {synth_rate_sel, mclk_in_sel},
          synth_mode ? {s[1][5], s[1][2:0], 4'h0} : {4'h0, s[1][5], s[1][2:0]});
    check("polarity", {bitclk_polarity, frame_polarity, mclk_out_rate},
          {s[1][3], s[1][4], s[1][7:6]});
    check("timers", {fast_recovery_speed, recovery_wait, zero_cross_timeout},
          {s[2][1:0], s[2][6], s[2][3:2], s[2][5:4]});
    check("transition", vol_transition_time, s[2][7] ? 11'h100 : 11'h425);
    check("limiter", {limiter_level, recovery_gain_step, limiter_atten_step},
          {s[7][6], s[3][0], s[7][7], s[3][1], s[3][3:2]});
    check("level", {limiter_zero_cross_off, level_ctrl_on, recovery_reference},
          {s[3][4], s[3][5], s[4]});
    check("in vol", {left_in_vol, right_in_vol}, {s[5], s[11][3] ? s[5] : s[8]});
    check("out vol", {left_out_vol, right_out_vol}, {s[6], s[10][4] ? s[6] : s[9]});
    check("effects", {deemph_sel, bass_boost_sel, soft_mute, dac_from_tx, headphone_mono},
          {s[10][1:0], s[10][3:2], s[10][5], s[10][6], s[11][2]});
    check("routing", {record_input_sel, filter_enable_bits}, {s[12], s[13]});
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    host_u.write_seq(DEV_ADDR_DEFAULT, ofs, d, 8'h00, 1, ok);
    check("write ack", ok, 1'b1);
    if (ofs >= REG_FIRST && ofs <= REG_LAST) shadow[ofs - REG_FIRST] = d;
  endtask

  // Unmapped offsets read back as zero.
  task automatic rd_chk(input logic [7:0] ofs);
    logic [7:0] v, e;
    host_u.read_seq(DEV_ADDR_DEFAULT, ofs, v, ok);
    e = (ofs >= REG_FIRST && ofs <= REG_LAST) ? shadow[ofs - REG_FIRST] : 8'h00;
    check($sformatf("reg %h", ofs), {ok, v}, {1'b1, e});
  endtask

  task automatic check_all();
    check_fields();
    for (int i = 0; i < 14; i++) rd_chk(REG_FIRST + 8'(i));
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs roughly 38000 cycles; this leaves ample margin.
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    synth_mode = 1'b0;
    shadow = DFLT;
    tick(6);
    rst = 1'b0;
    tick(6);
    check_all();
    // Table rows, alternating the clock mode so both readings of the rate field show.
    for (int i = 0; i < 16; i++) begin
      synth_mode = i[0];
      wr(ROWS[i].ofs, ROWS[i].wd);
      shadow[ROWS[i].ofs - REG_FIRST] = ROWS[i].rd;
      rd_chk(ROWS[i].ofs);
      check_fields();
    end
    // Linked volumes: left drives both, right registers keep their own bytes.
    wr(OFS_PLAYBACK_EFFECTS, 8'h11);
    wr(OFS_HEADPHONE_ROUTING, 8'h08);
    wr(OFS_LEFT_OUTPUT_VOLUME, 8'h40);
    wr(OFS_LEFT_INPUT_VOLUME, 8'h3C);
    check_fields();
    rd_chk(OFS_RIGHT_OUTPUT_VOLUME);
    rd_chk(OFS_RIGHT_INPUT_VOLUME);
    // Two bytes back to back land in consecutive registers.
    host_u.write_seq(DEV_ADDR_DEFAULT, OFS_RECORD_INPUT_SELECT, 8'h3C, 8'h18, 2, ok);
    check("pair ack", ok, 1'b1);
    shadow[12] = 8'h3C;
    shadow[13] = 8'h18;
    rd_chk(OFS_RECORD_INPUT_SELECT);
    rd_chk(OFS_FILTER_ENABLES);
    check_fields();
    // Writes outside the window change nothing; those places read zero.
    wr(8'h20, 8'h5A);
    rd_chk(8'h20);
    rd_chk(8'h03);
    check_fields();
    // A transfer to another device address is not acknowledged and not stored.
    host_u.write_seq(DEV_ADDR_DEFAULT ^ 7'h01, OFS_RECOVERY_REFERENCE_LEVEL, 8'h77, 8'h00, 1, ok);
    check("foreign ack", ok, 1'b0);
    rd_chk(OFS_RECOVERY_REFERENCE_LEVEL);
    // Power-down pin low restores every default.
    power_down_n = 1'b0;
    tick(6);
    power_down_n = 1'b1;
    tick(6);
    shadow = DFLT;
    check_all();
    give_verdict();
  end
endmodule

`default_nettype wire
